// *** hdl/ccq_decode.sv ***
// Purpose: decode and validate a create I/O completion queue admin command
// Assumes: command words arrive with a one cycle valid strobe while idle
// Notes: a queue is only bound after every check has passed
`default_nettype none
module ccq_decode #(
  parameter int NUM_QUEUES = 64,
  parameter int MAX_ENTRIES = 4096
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // command in
  input wire logic I_CMD_VALID,
  input wire ccq_pkg::ccq_cmd_t I_CMD,
  // controller configuration
  input wire logic [3:0] I_MEMORY_PAGE_SIZE_SETTING,
  input wire logic [15:0] I_MAX_QUEUE_ENTRIES_SUPPORTED,
  input wire logic [15:0] I_IO_CQ_COUNT,
  input wire logic [1:0] I_IRQ_MODE,
  input wire logic [11:0] I_MSIX_TABLE_SIZE,
  input wire logic [2:0] I_MSI_ENABLED_MESSAGE_COUNT,
  // queue release from the delete path
  input wire logic I_DELETE_VALID,
  input wire logic [15:0] I_DELETE_ID,
  // queue creation out
  output logic O_CREATE_VALID,
  output ccq_pkg::ccq_queue_t O_QUEUE,
  // completion out
  output logic O_CPL_VALID,
  output ccq_pkg::ccq_status_t O_CPL_STATUS,
  output logic O_BUSY
);
  // refuse sizes that the 16 bit identifier compares and casts cannot serve
  if (NUM_QUEUES < 2 || NUM_QUEUES > 65535) begin : g_bad_num_queues
    $error("NUM_QUEUES out of range");
  end
  if (MAX_ENTRIES < 2 || MAX_ENTRIES > 65536) begin : g_bad_max_entries
    $error("MAX_ENTRIES out of range");
  end

  // whole module state apart from the two reset release flops
  typedef struct packed {
    ccq_pkg::ccq_state_t state;
    ccq_pkg::ccq_cmd_t cmd;
    logic [NUM_QUEUES-1:0] in_use;
    logic create;
    ccq_pkg::ccq_queue_t queue;
    logic cpl;
    ccq_pkg::ccq_status_t status;
    logic busy; // busy flag kept as a flop so the output is registered
  } ccq_regs_t;

  ccq_regs_t r_ff;
  ccq_regs_t nxt_r;
  logic rst_meta_ff;
  logic rst_sync_ff;

  // page alignment mask from page size setting, 4KiB times two to the setting
  function automatic logic [63:0] page_mask(input logic [3:0] setting);
    page_mask = (64'h0000_0000_0000_1000 << setting) - 64'h0000_0000_0000_0001;
  endfunction : page_mask

  // reset release through two flops
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // field extraction, only pointer and words ten and eleven are read
  logic [15:0] f_id;
  logic [15:0] f_size;
  logic [15:0] f_vec;
  logic f_int_en;
  logic f_contig;
  logic [16:0] f_entries;
  logic [16:0] vec_limit;
  assign f_id = r_ff.cmd.command_word_ten[ccq_pkg::ID_LSB +: 16];
  assign f_size = r_ff.cmd.command_word_ten[ccq_pkg::SIZE_LSB +: 16];
  assign f_vec = r_ff.cmd.command_word_eleven[ccq_pkg::VEC_LSB +: 16];
  assign f_int_en = r_ff.cmd.command_word_eleven[ccq_pkg::INT_EN_BIT];
  assign f_contig = r_ff.cmd.command_word_eleven[ccq_pkg::CONTIG_BIT];
  assign f_entries = {1'b0, f_size} + 17'h0_0001;

  // number of usable vectors for the current interrupt mode
  always_comb begin
    case (I_IRQ_MODE)
      ccq_pkg::IRQ_MSIX: begin
        vec_limit = {5'h00, I_MSIX_TABLE_SIZE} + 17'h0_0001;
        if (vec_limit > 17'(ccq_pkg::MSIX_MAX_VECTORS)) begin
          vec_limit = 17'(ccq_pkg::MSIX_MAX_VECTORS);
        end
      end
      ccq_pkg::IRQ_MSI: vec_limit = 17'h0_0001 << I_MSI_ENABLED_MESSAGE_COUNT;
      default: vec_limit = 17'h0_0001;
    endcase
  end

  // checks, in status priority order
  logic bad_id;
  logic bad_size;
  logic bad_vec;
  logic bad_align;
  logic id_busy;
  always_comb begin
    id_busy = 1'b0;
    if (f_id < 16'(NUM_QUEUES)) begin
      id_busy = r_ff.in_use[f_id[$clog2(NUM_QUEUES)-1:0]];
    end
    // queue zero is the admin queue and never made here
    bad_id = (f_id == 16'h0000) || ({1'b0, f_id} > {1'b0, I_IO_CQ_COUNT}) ||
             (f_id >= 16'(NUM_QUEUES)) || id_busy;
    bad_size = (f_size == 16'h0000) || (f_size > I_MAX_QUEUE_ENTRIES_SUPPORTED) ||
               (f_entries > 17'(MAX_ENTRIES));
    bad_vec = {1'b0, f_vec} >= vec_limit;
    // pointer must be page aligned in both layouts
    bad_align = (r_ff.cmd.first_page_pointer & page_mask(I_MEMORY_PAGE_SIZE_SETTING))
                != 64'h0000_0000_0000_0000;
  end

  // next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.create = 1'b0;
    nxt_r.cpl = 1'b0;
    // a delete frees its identifier
    if (I_DELETE_VALID && (I_DELETE_ID < 16'(NUM_QUEUES))) begin
      nxt_r.in_use[I_DELETE_ID[$clog2(NUM_QUEUES)-1:0]] = 1'b0;
    end
    case (r_ff.state)
      ccq_pkg::ST_IDLE: begin
        if (I_CMD_VALID) begin
          nxt_r.cmd = I_CMD;
          nxt_r.state = ccq_pkg::ST_CHECK;
        end
      end
      ccq_pkg::ST_CHECK: begin
        nxt_r.cpl = 1'b1;
        nxt_r.state = ccq_pkg::ST_DONE;
        nxt_r.status.sct = ccq_pkg::SCT_CMD_SPECIFIC;
        if (bad_id) begin
          nxt_r.status.sc = ccq_pkg::SC_BAD_ID;
        end else if (bad_size) begin
          nxt_r.status.sc = ccq_pkg::SC_SIZE_EXCEEDED;
        end else if (bad_vec) begin
          nxt_r.status.sc = ccq_pkg::SC_BAD_VECTOR;
        end else if (bad_align) begin
          // misaligned pointer is a generic invalid field
          nxt_r.status.sct = ccq_pkg::SCT_GENERIC;
          nxt_r.status.sc = ccq_pkg::SC_INVALID_FIELD;
        end else begin
          // all checks passed: only now bind the queue
          nxt_r.status.sct = ccq_pkg::SCT_GENERIC;
          nxt_r.status.sc = ccq_pkg::SC_SUCCESS;
          nxt_r.create = 1'b1;
          nxt_r.in_use[f_id[$clog2(NUM_QUEUES)-1:0]] = 1'b1;
          nxt_r.queue.base = r_ff.cmd.first_page_pointer;
          nxt_r.queue.contiguous_flag = f_contig;
          nxt_r.queue.queue_identifier = f_id;
          nxt_r.queue.entries = f_entries;
          nxt_r.queue.interrupt_vector_number = f_vec;
          nxt_r.queue.interrupt_enable_flag = f_int_en;
        end
      end
      ccq_pkg::ST_DONE: nxt_r.state = ccq_pkg::ST_IDLE;
      default: nxt_r.state = ccq_pkg::ST_IDLE;
    endcase
    // busy follows the next state so the output needs no decode
    nxt_r.busy = (nxt_r.state != ccq_pkg::ST_IDLE);
  end

  // state register
  always_ff @(posedge I_CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from flops
  assign O_CREATE_VALID = r_ff.create;
  assign O_QUEUE = r_ff.queue;
  assign O_CPL_VALID = r_ff.cpl;
  assign O_CPL_STATUS = r_ff.status;
  assign O_BUSY = r_ff.busy;

  // every accepted command completes two cycles later
  sequence s_accept;
    !O_BUSY && I_CMD_VALID;
  endsequence
  property p_cpl_after_cmd;
    @(posedge I_CLK) disable iff (!rst_sync_ff) s_accept |=> ##1 O_CPL_VALID;
  endproperty
  a_cpl_after_cmd: assert property (p_cpl_after_cmd) else $error("no completion");

  // creation only together with success completion
  property p_create_success;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_CPL_VALID && O_CPL_STATUS.sc == ccq_pkg::SC_SUCCESS &&
      O_CPL_STATUS.sct == ccq_pkg::SCT_GENERIC;
  endproperty
  a_create_success: assert property (p_create_success) else $error("create w/o ok");

  // failed completion never creates
  property p_fail_no_create;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CPL_VALID && O_CPL_STATUS.sc != ccq_pkg::SC_SUCCESS |-> !O_CREATE_VALID;
  endproperty
  a_fail_no_create: assert property (p_fail_no_create) else $error("bad create");

  // admin queue identifier never created
  property p_no_admin;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.queue_identifier != 16'h0000;
  endproperty
  a_no_admin: assert property (p_no_admin) else $error("admin queue created");

  // entry count is size field plus one
  property p_entries;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.entries == {1'b0, $past(f_size)} + 17'h0_0001;
  endproperty
  a_entries: assert property (p_entries) else $error("entry count wrong");

  // flags taken from word eleven bits one and zero
  property p_flags;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.interrupt_enable_flag == $past(f_int_en) &&
      O_QUEUE.contiguous_flag == $past(f_contig);
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");

  // vector taken from word eleven and below msix ceiling
  property p_vector;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.interrupt_vector_number == $past(f_vec) &&
      O_QUEUE.interrupt_vector_number < 16'h0800;
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");

  // base is 4KiB aligned when created
  property p_align;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.base[11:0] == 12'h000;
  endproperty
  a_align: assert property (p_align) else $error("base misaligned");

  // identifier from word ten low half, reused id rejected
  property p_qid;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.queue_identifier == $past(f_id) && !$past(id_busy);
  endproperty
  a_qid: assert property (p_qid) else $error("identifier wrong");

  // a taken command keeps the block busy two cycles, then frees it
  sequence s_busy_window;
    O_BUSY ##1 O_BUSY ##1 !O_BUSY;
  endsequence
  property p_busy_window;
    @(posedge I_CLK) disable iff (!rst_sync_ff) s_accept |=> s_busy_window;
  endproperty
  a_busy_window: assert property (p_busy_window) else $error("busy window wrong");

  // a strobe while busy is dropped and never yields a completion
  sequence s_refused;
    O_BUSY && I_CMD_VALID;
  endsequence
  property p_refused;
    @(posedge I_CLK) disable iff (!rst_sync_ff) s_refused |=> ##1 !O_CPL_VALID;
  endproperty
  a_refused: assert property (p_refused) else $error("refused cmd completed");

  // completion strobe lasts exactly one cycle
  property p_cpl_pulse;
    @(posedge I_CLK) disable iff (!rst_sync_ff) O_CPL_VALID |=> !O_CPL_VALID;
  endproperty
  a_cpl_pulse: assert property (p_cpl_pulse) else $error("completion too long");

  // status only moves together with a completion strobe
  property p_status_hold;
    @(posedge I_CLK) disable iff (!rst_sync_ff) !O_CPL_VALID |-> $stable(O_CPL_STATUS);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved");

  // a created queue respects the reported id count and size ceiling
  property p_limits;
    @(posedge I_CLK) disable iff (!rst_sync_ff)
      O_CREATE_VALID |-> O_QUEUE.queue_identifier <= $past(I_IO_CQ_COUNT) &&
      O_QUEUE.entries <= {1'b0, $past(I_MAX_QUEUE_ENTRIES_SUPPORTED)} + 17'h0_0001;
  endproperty
  a_limits: assert property (p_limits) else $error("limits broken");
endmodule : ccq_decode
`default_nettype wire

// *** hdl/ccq_pkg.sv ***
// Purpose: constants and carrier types for the completion queue creation decoder
// Assumes: one core clock, admin command fields handed over as whole words
// Notes: status codes are the generic and command specific values of the admin completion entry
`default_nettype none
package ccq_pkg;
  // command word 10 fields
  localparam int SIZE_LSB = 16;
  localparam int ID_LSB = 0;
  // command word 11 fields
  localparam int VEC_LSB = 16;
  localparam int INT_EN_BIT = 1;
  localparam int CONTIG_BIT = 0;
  // largest vector count in msix operation
  localparam int MSIX_MAX_VECTORS = 2048;
  // status code type values
  localparam logic [2:0] SCT_GENERIC = 3'h0;
  localparam logic [2:0] SCT_CMD_SPECIFIC = 3'h1;
  // status codes
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
  localparam logic [7:0] SC_BAD_ID = 8'h01;
  localparam logic [7:0] SC_SIZE_EXCEEDED = 8'h02;
  localparam logic [7:0] SC_BAD_VECTOR = 8'h08;
  // interrupt modes
  localparam logic [1:0] IRQ_PIN = 2'h0;
  localparam logic [1:0] IRQ_MSI = 2'h1;
  localparam logic [1:0] IRQ_MSIX = 2'h2;
  // reset values
  localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;
  // controller states
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_DONE} ccq_state_t;
  // incoming command
  typedef struct packed {
    logic [63:0] first_page_pointer;
    logic [31:0] command_word_ten;
    logic [31:0] command_word_eleven;
  } ccq_cmd_t;
  // new queue description handed to queue and doorbell logic
  typedef struct packed {
    logic [63:0] base;
    logic contiguous_flag;
    logic [15:0] queue_identifier;
    logic [16:0] entries;
    logic [15:0] interrupt_vector_number;
    logic interrupt_enable_flag;
  } ccq_queue_t;
  // completion status
  typedef struct packed {
    logic [2:0] sct;
    logic [7:0] sc;
  } ccq_status_t;
endpackage : ccq_pkg
`default_nettype wire

// *** dv/ccq_host.sv ***
// Purpose: host side model that hands one admin command to the decoder
// Assumes: called at a falling edge while the decoder is idle
// Notes: a stray command can be held up while busy to probe refusal
`default_nettype none
module ccq_host (
  // clock
  input wire logic i_clk,
  // command out
  output logic o_cmd_valid,
  output ccq_pkg::ccq_cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  // pointer and both words are held with the strobe
  // the bench picks ids and vectors, legal or not on purpose
  task automatic send(input ccq_pkg::ccq_cmd_t c, input logic stray,
                      input ccq_pkg::ccq_cmd_t junk);
    o_cmd_valid = 1'b1;
    o_cmd = c;
    @(negedge i_clk);
    // a second command while busy must be dropped
    if (stray) begin
      o_cmd = junk;
      @(negedge i_clk);
    end
    // released words no longer show the old value
    o_cmd_valid = 1'b0;
    o_cmd = ~c;
  endtask : send
endmodule : ccq_host
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self checking bench for the completion queue creation decoder
// Assumes: inputs change at falling edges, outputs read at falling edges
// Notes: expected status and queue come from a bench model of the checks
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NQ = 64;
  localparam int ME = 4096;
  // expected result of one command
  typedef struct {logic [10:0] st; ccq_pkg::ccq_queue_t q; int t;} ccq_note_t;
  logic clk;
  logic rst_n = 1'b0;
  logic [3:0] pg_set = 4'h0;
  logic [15:0] max_ent = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic [1:0] mode = 2'h0;
  logic [11:0] tbl_sz = 12'h000;
  logic [2:0] msi = 3'h0;
  logic del_v = 1'b0;
  logic [15:0] del_q = 16'h0000;
  logic cmd_v;
  ccq_pkg::ccq_cmd_t cmd;
  logic cre_v;
  ccq_pkg::ccq_queue_t q;
  logic cpl_v;
  ccq_pkg::ccq_status_t sts;
  logic busy;
  logic [63:0] used = '0; // ids the bench believes are live
  ccq_note_t notes[$];
  ccq_note_t mon_n;
  ccq_pkg::ccq_cmd_t c;
  int cyc = 0;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] tw[4] = '{32'h0fff_003f, 32'h0fff_003f, 32'h0001_003e, 32'h0001_0000};
  logic [31:0] te[4] = '{32'h07ff_0003, 32'h0000_0001, 32'h0800_0002, 32'h0000_0000};
  ccq_host h (.i_clk(clk), .o_cmd_valid(cmd_v), .o_cmd(cmd));
  ccq_decode #(.NUM_QUEUES(NQ), .MAX_ENTRIES(ME)) dut (
    .I_CLK(clk), .I_RESETN(rst_n), .I_CMD_VALID(cmd_v), .I_CMD(cmd),
    .I_MEMORY_PAGE_SIZE_SETTING(pg_set), .I_MAX_QUEUE_ENTRIES_SUPPORTED(max_ent),
    .I_IO_CQ_COUNT(cnt), .I_IRQ_MODE(mode), .I_MSIX_TABLE_SIZE(tbl_sz),
    .I_MSI_ENABLED_MESSAGE_COUNT(msi), .I_DELETE_VALID(del_v), .I_DELETE_ID(del_q),
    .O_CREATE_VALID(cre_v), .O_QUEUE(q), .O_CPL_VALID(cpl_v), .O_CPL_STATUS(sts),
    .O_BUSY(busy));
  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycle count and hang guard
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  // status by check priority: id, size, vector, alignment
  function automatic logic [10:0] exp_st(input ccq_pkg::ccq_cmd_t x);
    logic [15:0] id;
    logic [15:0] qs;
    int lim;
    id = x.command_word_ten[15:0];
    qs = x.command_word_ten[31:16];
    lim = (mode == 2'h1) ? (1 << msi) :
          (mode == 2'h2) ? ((tbl_sz >= 12'h7ff) ? 2048 : tbl_sz + 1) : 1;
    if (id == 0 || id > cnt || id >= NQ || used[id[5:0]]) return 11'h101;
    if (qs == 0 || qs > max_ent || qs >= ME) return 11'h102;
    if (x.command_word_eleven[31:16] >= lim) return 11'h108;
    if ((x.first_page_pointer & ((64'h1000 << pg_set) - 64'h1)) != 0) return 11'h002;
    return 11'h000;
  endfunction : exp_st
  // wait for idle, note the expectation, hand the command over
  task automatic issue(input ccq_pkg::ccq_cmd_t x, input logic stray);
    ccq_note_t n;
    int k;
    k = 0;
    do @(negedge clk); while (busy !== 1'b0 && ++k < 20);
    n.st = exp_st(x);
    n.q = {x.first_page_pointer, x.command_word_eleven[0], x.command_word_ten[15:0],
           {1'b0, x.command_word_ten[31:16]} + 17'h1, x.command_word_eleven[31:16],
           x.command_word_eleven[1]};
    n.t = cyc;
    if (n.st == 11'h000) used[x.command_word_ten[5:0]] = 1'b1;
    notes.push_back(n);
    h.send(x, stray, ~x);
    // let the check cycle pass before the caller moves the configuration
    @(negedge clk);
  endtask : issue
  task automatic del(input logic [15:0] id);
    @(negedge clk);
    del_v = 1'b1;
    del_q = id;
    if (id < NQ) used[id[5:0]] = 1'b0;
    @(negedge clk);
    del_v = 1'b0;
  endtask : del
  // watcher: every completion matched to the oldest note
  always @(negedge clk) begin
    if (cpl_v === 1'b1) begin
      if (notes.size() == 0) chk(1'b0, "completion without command");
      else begin
        mon_n = notes.pop_front();
        chk(cyc === mon_n.t + 2, "completion latency");
        chk(busy === 1'b1, "busy at completion");
        chk({sts.sct, sts.sc} === mon_n.st, "completion status");
        chk(cre_v === (mon_n.st == 11'h000), "create strobe");
        if (mon_n.st == 11'h000) chk(q === mon_n.q, "queue fields");
      end
    end else if (cre_v === 1'b1) chk(1'b0, "create without completion");
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(93159));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // random configurations, fields, reserved bits, strays and deletes
    for (int i = 0; i < 300; i++) begin
      mode = 2'($urandom);
      pg_set = 4'($urandom % 3);
      max_ent = 16'($urandom % 5000);
      cnt = 16'($urandom % 80);
      tbl_sz = ($urandom % 4 == 0) ? 12'($urandom) : 12'($urandom % 40);
      msi = 3'($urandom);
      if ($urandom % 5 == 0) del(16'($urandom % 72));
      c.command_word_ten = {16'($urandom % 5000), 16'($urandom % 72)};
      if ($urandom % 8 == 0) c.command_word_ten[31:16] = 16'($urandom);
      c.command_word_eleven = $urandom;
      c.command_word_eleven[31:16] = ($urandom % 3 == 0) ? 16'h0000 : 16'($urandom % 40);
      c.first_page_pointer = {$urandom, $urandom};
      if ($urandom % 6 != 0) c.first_page_pointer &= ~((64'h1000 << pg_set) - 64'h1);
      issue(c, 1'($urandom % 4 == 0));
    end
    $display("test random create done");
    // edge values: full size, top vector, duplicate id, id zero
    mode = 2'h2;
    tbl_sz = 12'hfff;
    cnt = 16'h003f;
    max_ent = 16'h0fff;
    pg_set = 4'h0;
    del(16'h003f);
    del(16'h003e);
    for (int i = 0; i < 4; i++) begin
      c.first_page_pointer = 64'h0000_0000_0001_0000;
      c.command_word_ten = tw[i];
      c.command_word_eleven = te[i];
      issue(c, 1'b0);
    end
    repeat (10) @(negedge clk);
    chk(notes.size() == 0, "completions missing");
    $display("test boundaries done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
